/* verilog/hpc_top.sv */
// Purpose: Performance counter unit reached by CSR accesses
// Assumes: i_clk is the core's gated clock; requests and
//          event pulses come from logic on the same clock
// Notes:   Answer and trap flag come one cycle after request
//
// Overview of operation
// - Registers support write, set, clear, immediate forms
// - Cycle, retired and event counters are 64-bit
// - Event counter quantity parameter, 0 to 29
// - Unimplemented event counters read as zero
// - Counters run on gated core clock
// - Selector bits 0-7: tick through unconditional jump
// - Selector bits 8-15: branches through FP writeback
// - Counter adds one per cycle with any event set in its selector
// - Zero selector means no counting
// - All counters inhibited after reset
// - Inhibit register at 0x320 gates each counter
// - Inhibit bit 0 cycle, 2 retired, X event
// - Low and high halves in separate registers
// - Reads never disturb counter value or counting
// - Each event counter: 64-bit count, selector, inhibit
// - Time registers absent, access traps illegal
// - Selectors 3..31 at 0x323 to 0x33F
// - Unimplemented CSR access raises illegal
`timescale 1ns/1ps
`include "hpc_consts.svh"

module hpc_top #(
    parameter int EVENT_TALLY_QUANTITY = 1 // Event counters, 0 to 29
) (
    input wire logic i_clk, // Gated core clock
    input wire logic i_reset, // Synchronous reset, high
    input wire hpc_pkg::hpc_csr_req_type i_csr_req, // CSR request
    input wire hpc_pkg::hpc_events_type i_events, // Event pulses
    output hpc_pkg::hpc_csr_resp_type o_csr_resp // CSR answer
);

    // ----------------------------------------
    // Derived constants
    // ----------------------------------------

    // Out-of-range settings are clamped rather than rejected
    localparam int NUM_EVT = (EVENT_TALLY_QUANTITY < 0) ? 0 :
        (EVENT_TALLY_QUANTITY > `HPC_EVENT_TALLY_MAX) ? `HPC_EVENT_TALLY_MAX :
        EVENT_TALLY_QUANTITY;
    localparam int FIRST_EVT = 3;
    localparam int END_EVT = FIRST_EVT + NUM_EVT;

    // Block bases, compared on address bits 11:5
    // Each block spans 32 slots, so bits 4:0 pick the slot
    localparam logic [11:0] A_MLO = `HPC_ADDR_MCNT_LO;
    localparam logic [11:0] A_MHI = `HPC_ADDR_MCNT_HI;
    localparam logic [11:0] A_ULO = `HPC_ADDR_UCNT_LO;
    localparam logic [11:0] A_UHI = `HPC_ADDR_UCNT_HI;
    localparam logic [11:0] A_CTL = `HPC_ADDR_INHIBIT;

    // implemented inhibit bits
    // Bit 1 belongs to the absent time counter and stays zero
    localparam logic [31:0] INH_MASK =
        32'((32'h0000_0001 << END_EVT) - 32'h0000_0001) & ~`HPC_INH_TIME_BIT;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [4:0] idx;
    logic [15:0] ev;
    logic in_mlo;
    logic in_mhi;
    logic in_ulo;
    logic in_uhi;
    logic in_ctl;
    logic is_cnt;
    logic is_hi;
    logic is_user;
    logic is_time;
    logic is_inh;
    logic is_sel;
    logic wants_write;
    logic legal;
    logic do_write;
    logic [31:0] operand;
    logic [31:0] old_val;
    logic [31:0] new_val;
    logic [31:0] wr_lo_vec;
    logic [31:0] wr_hi_vec;
    logic [31:0] wr_sel_vec;
    logic [31:0] inc_vec;
    logic [63:0] cnt_w [32];
    logic [15:0] sel_w [32];
    logic [31:0] inh_ff;
    logic [31:0] nxt_inh;
    hpc_pkg::hpc_csr_resp_type resp_ff;
    hpc_pkg::hpc_csr_resp_type nxt_resp;

    // Slot index and flat event vector
    assign idx = i_csr_req.addr[4:0];
    assign ev = i_events;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------

    // Block hits
    always_comb begin
        in_mlo = (i_csr_req.addr[11:5] == A_MLO[11:5]);
        in_mhi = (i_csr_req.addr[11:5] == A_MHI[11:5]);
        in_ulo = (i_csr_req.addr[11:5] == A_ULO[11:5]);
        in_uhi = (i_csr_req.addr[11:5] == A_UHI[11:5]);
        in_ctl = (i_csr_req.addr[11:5] == A_CTL[11:5]);
    end

    always_comb begin
        is_cnt = in_mlo | in_mhi | in_ulo | in_uhi;
        is_hi = in_mhi | in_uhi;
        is_user = in_ulo | in_uhi;
    end

    always_comb begin
        is_time = is_cnt && (idx == `HPC_IDX_TIME);
    end

    always_comb begin
        is_inh = in_ctl && (idx == `HPC_IDX_INHIBIT);
        is_sel = in_ctl && (idx >= `HPC_IDX_FIRST_EVT);
    end

    // ----------------------------------------
    // Access legality
    // ----------------------------------------

    // Set or clear with a zero source is a pure read
    // Code 0 never writes, whatever its source field holds
    always_comb begin
        wants_write = 1'h0;
        if (i_csr_req.op == hpc_pkg::HPC_OP_WRITE) begin
            wants_write = 1'h1;
        end else if (i_csr_req.op == hpc_pkg::HPC_OP_SET || i_csr_req.op == hpc_pkg::HPC_OP_CLEAR) begin
            wants_write = !i_csr_req.src_zero;
        end
    end

    // unmapped address traps
    // User aliases are read-only; a real write to them traps
    // Absent event slots stay legal: reads zero, writes dropped
    always_comb begin
        legal = 1'h0;
        if (is_cnt) begin
            legal = !is_time && !(is_user && wants_write);
        end else if (is_inh || is_sel) begin
            legal = 1'h1;
        end
    end

    // A trapped access changes nothing
    always_comb begin
        do_write = i_csr_req.valid && legal && wants_write;
    end

    // ----------------------------------------
    // Read value and write value
    // ----------------------------------------

    // reads only select
    // No 64-bit snapshot: software rereads the high half
    always_comb begin
        old_val = 32'h0000_0000;
        if (is_cnt) begin
            if (is_hi) begin
                old_val = cnt_w[idx][63:32];
            end else begin
                old_val = cnt_w[idx][31:0];
            end
        end else if (is_inh) begin
            old_val = inh_ff;
        end else if (is_sel) begin
            old_val = {16'h0000, sel_w[idx]};
        end
    end

    always_comb begin
        if (i_csr_req.use_imm) begin
            operand = {27'h000_0000, i_csr_req.uimm};
        end else begin
            operand = i_csr_req.wdata;
        end
    end

    // write, set, clear
    // Code 0 is not an operation and leaves the value alone
    always_comb begin
        case (i_csr_req.op)
            hpc_pkg::HPC_OP_WRITE: begin
                new_val = operand;
            end
            hpc_pkg::HPC_OP_SET: begin
                new_val = old_val | operand;
            end
            hpc_pkg::HPC_OP_CLEAR: begin
                new_val = old_val & ~operand;
            end
            default: begin
                new_val = old_val;
            end
        endcase
    end

    // One-hot write strobes per slot
    // Absent slots get a strobe that nothing listens to
    always_comb begin
        wr_lo_vec = 32'h0000_0000;
        wr_hi_vec = 32'h0000_0000;
        wr_sel_vec = 32'h0000_0000;
        if (do_write && is_cnt && !is_hi) begin
            wr_lo_vec = 32'h0000_0001 << idx;
        end
        if (do_write && is_cnt && is_hi) begin
            wr_hi_vec = 32'h0000_0001 << idx;
        end
        if (do_write && is_sel) begin
            wr_sel_vec = 32'h0000_0001 << idx;
        end
    end

    // ----------------------------------------
    // Counter-inhibit register
    // ----------------------------------------

    // Only implemented bits are kept; others read as zero
    // Bit 1 stays clear; slot 1 never runs since its increment is tied to zero
    always_comb begin
        nxt_inh = inh_ff;
        if (do_write && is_inh) begin
            nxt_inh = new_val & INH_MASK;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            inh_ff <= `HPC_INHIBIT_RST & INH_MASK;
        end else begin
            inh_ff <= nxt_inh;
        end
    end

    // ----------------------------------------
    // Counter slots
    // ----------------------------------------

    // gated clock drives all
    // Sleep stops i_clk upstream, so no enable is needed here
    // Trade-off: a full adder per implemented slot, simple but costly in area
    for (genvar k = 0; k < 32; k++) begin : g_slot
        if (k == 0 || k == 2 || (k >= FIRST_EVT && k < END_EVT)) begin : g_cnt
            hpc_counter u_counter (
                .i_clk(i_clk),
                .i_reset(i_reset),
                .i_inc(inc_vec[k]),
                .i_wr_lo(wr_lo_vec[k]),
                .i_wr_hi(wr_hi_vec[k]),
                .i_wdata(new_val),
                .o_count(cnt_w[k])
            );
        end else begin : g_no_cnt
            assign cnt_w[k] = `HPC_CNT_RST;
        end

        if (k >= FIRST_EVT && k < END_EVT) begin : g_sel
            logic [15:0] sel_ff;

            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    sel_ff <= `HPC_SEL_RST;
                end else if (wr_sel_vec[k]) begin
                    sel_ff <= new_val[15:0];
                end
            end

            assign sel_w[k] = sel_ff;
            assign inc_vec[k] = ~inh_ff[k] & (|(sel_ff & ev));
        end else begin : g_no_sel
            assign sel_w[k] = `HPC_SEL_RST;
            if (k == 0) begin : g_cyc
                assign inc_vec[k] = ~inh_ff[k];
            end else if (k == 2) begin : g_ret
                assign inc_vec[k] = ~inh_ff[k] & i_events.retirement_event;
            end else begin : g_idle
                assign inc_vec[k] = 1'h0;
            end
        end
    end

    // ----------------------------------------
    // Answer to the pipeline
    // ----------------------------------------

    // trap flag on illegal
    // Read data is the value before any write of the same access
    // A trapped access answers zero so no stale value leaks
    always_comb begin
        nxt_resp.valid = i_csr_req.valid;
        nxt_resp.illegal = i_csr_req.valid && !legal;
        nxt_resp.rdata = 32'h0000_0000;
        if (i_csr_req.valid && legal) begin
            nxt_resp.rdata = old_val;
        end
    end

    // Registered so the output comes from a flip-flop
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            resp_ff.valid <= 1'h0;
            resp_ff.illegal <= 1'h0;
            resp_ff.rdata <= 32'h0000_0000;
        end else begin
            resp_ff <= nxt_resp;
        end
    end

    assign o_csr_resp = resp_ff;

endmodule : hpc_top

/* verilog/hpc_consts.svh */
// Purpose: Shared constants of the performance counter unit
// Assumes: Included by its bare name from every file that uses its macros
// Notes:   Definitions only, no logic
`ifndef HPC_CONSTS_SVH
`define HPC_CONSTS_SVH

// ----------------------------------------
// CSR address blocks, 32 entries each
// ----------------------------------------
`define HPC_ADDR_MCNT_LO 12'hB00
`define HPC_ADDR_MCNT_HI 12'hB80
`define HPC_ADDR_UCNT_LO 12'hC00
`define HPC_ADDR_UCNT_HI 12'hC80
`define HPC_ADDR_INHIBIT 12'h320

// ----------------------------------------
// Slot indices inside a block
// ----------------------------------------
`define HPC_IDX_CYCLE 5'h00
`define HPC_IDX_TIME 5'h01
`define HPC_IDX_RETIRED 5'h02
`define HPC_IDX_FIRST_EVT 5'h03
`define HPC_IDX_INHIBIT 5'h00
`define HPC_EVENT_TALLY_MAX 29

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define HPC_INH_TIME_BIT 32'h0000_0002
`define HPC_INHIBIT_RST 32'hFFFF_FFFF
`define HPC_SEL_RST 16'h0000
`define HPC_CNT_RST 64'h0000_0000_0000_0000
`define HPC_CNT_ONE 64'h0000_0000_0000_0001

`endif

/* verilog/hpc_pkg.sv */
// Purpose: Types of the performance counter unit
// Assumes: Nothing is imported; users write hpc_pkg::name
// Notes:   Event struct lists bit 15 first, bit 0 last
package hpc_pkg;

    // ----------------------------------------
    // CSR operation, code 0 is unused
    // ----------------------------------------
    typedef enum logic [1:0] {
        HPC_OP_WRITE = 2'h1,
        HPC_OP_SET = 2'h2,
        HPC_OP_CLEAR = 2'h3
    } hpc_csr_op_type;

    // CSR request from the pipeline
    typedef struct packed {
        logic valid;
        hpc_csr_op_type op;
        logic use_imm;
        logic [4:0] uimm;
        logic src_zero;
        logic [11:0] addr;
        logic [31:0] wdata;
    } hpc_csr_req_type;

    // CSR answer, one cycle after the request
    typedef struct packed {
        logic valid;
        logic illegal;
        logic [31:0] rdata;
    } hpc_csr_resp_type;

    // One-cycle event pulses from the pipeline
    typedef struct packed {
        logic fp_unit_writeback_event;
        logic fp_unit_dependency_event;
        logic fp_unit_contention_event;
        logic fp_unit_type_conflict_event;
        logic pipe_stall_event;
        logic compressed_retire_event;
        logic taken_conditional_event;
        logic conditional_transfer_event;
        logic uncond_jump_event;
        logic memory_write_event;
        logic load_event;
        logic fetch_wait_event;
        logic register_jump_hazard_event;
        logic load_use_hazard_event;
        logic retirement_event;
        logic clock_tick_event;
    } hpc_events_type;

endpackage : hpc_pkg

/* verilog/hpc_counter.sv */
// Purpose: One 64-bit counter with half-word load
// Assumes: Loads of both halves never arrive together
// Notes:   A load wins over the increment in its cycle
`timescale 1ns/1ps
`include "hpc_consts.svh"

module hpc_counter (
    input wire logic i_clk, // Gated core clock
    input wire logic i_reset, // Synchronous reset, high
    input wire logic i_inc, // Count one this cycle
    input wire logic i_wr_lo, // Load low half
    input wire logic i_wr_hi, // Load high half
    input wire logic [31:0] i_wdata, // Load value
    output logic [63:0] o_count // Current count
);

    logic [63:0] count_ff;
    logic [63:0] nxt_count;

    always_comb begin
        nxt_count = count_ff;
        if (i_wr_lo) begin
            nxt_count[31:0] = i_wdata;
        end else if (i_wr_hi) begin
            nxt_count[63:32] = i_wdata;
        end else if (i_inc) begin
            // Full-width add carries into the high half
            nxt_count = count_ff + `HPC_CNT_ONE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            count_ff <= `HPC_CNT_RST;
        end else begin
            count_ff <= nxt_count;
        end
    end

    assign o_count = count_ff;

endmodule : hpc_counter

/* verification/hpc_checker.sv */
// Purpose: Port assertions for the counter unit
// Assumes: One clock, synchronous high reset
// Notes:   Bound into hpc_top below the module
`timescale 1ns/1ps

module hpc_checker #(
    parameter int EVENT_TALLY_QUANTITY = 1 // Event counters
) (
    input wire logic i_clk, // Core clock
    input wire logic i_reset, // Sync reset
    input wire hpc_pkg::hpc_csr_req_type i_csr_req, // CSR request
    input wire hpc_pkg::hpc_events_type i_events, // Event pulses
    input wire hpc_pkg::hpc_csr_resp_type o_csr_resp // CSR answer
);
    // ----
    // Address decode
    // ----
    logic ctr_blk;
    logic usr_wr;
    logic sel_blk;
    logic inh_reg;
    logic is_wr;
    logic [4:0] idx;

    // Counter blocks need bits 6:5 clear, else they are holes
    assign idx = i_csr_req.addr[4:0];
    assign ctr_blk = (i_csr_req.addr[11:7] inside {5'h16, 5'h17, 5'h18, 5'h19}) && (i_csr_req.addr[6:5] == 2'h0);
    assign is_wr = (i_csr_req.op == hpc_pkg::HPC_OP_WRITE) || (i_csr_req.op != 2'h0 && !i_csr_req.src_zero);
    assign usr_wr = ctr_blk && (i_csr_req.addr[11:8] == 4'hC) && is_wr;
    assign sel_blk = (i_csr_req.addr >= 12'h323) && (i_csr_req.addr <= 12'h33F);
    assign inh_reg = i_csr_req.addr == 12'h320;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // ----
    // Properties
    // ----
    answer_next_a: assert property (i_csr_req.valid |=> o_csr_resp.valid)
        else $error("no answer one cycle after request");
    answer_quiet_a: assert property (!i_csr_req.valid |=> !o_csr_resp.valid && o_csr_resp.rdata == 32'h0)
        else $error("answer without request");
    time_trap_a: assert property (i_csr_req.valid && ctr_blk && idx == 5'h01 |=> o_csr_resp.illegal)
        else $error("time register access not trapped");
    unmapped_trap_a: assert property (i_csr_req.valid && !ctr_blk && !sel_blk && !inh_reg
        |=> o_csr_resp.illegal && o_csr_resp.rdata == 32'h0)
        else $error("unmapped address not trapped");
    user_write_a: assert property (i_csr_req.valid && usr_wr |=> o_csr_resp.illegal)
        else $error("write to read-only alias not trapped");
    inhibit_legal_a: assert property (i_csr_req.valid && inh_reg |=> !o_csr_resp.illegal)
        else $error("inhibit register trapped");
    selector_legal_a: assert property (i_csr_req.valid && sel_blk
        |-> ##1 !o_csr_resp.illegal && o_csr_resp.rdata[31:16] == 16'h0)
        else $error("selector access wrong");
    counter_legal_a: assert property (i_csr_req.valid && ctr_blk && idx != 5'h01 && !usr_wr
        |=> !o_csr_resp.illegal)
        else $error("counter half access trapped");
    unimpl_zero_a: assert property (i_csr_req.valid && ctr_blk && idx >= 3 + EVENT_TALLY_QUANTITY && !usr_wr
        |=> o_csr_resp.rdata == 32'h0)
        else $error("absent counter reads nonzero");
    trap_cause_a: assert property (o_csr_resp.illegal |-> $past(i_csr_req.valid) && o_csr_resp.rdata == 32'h0)
        else $error("trap without request");

    // Main scenarios reached
    trap_seen_c: cover property (i_csr_req.valid ##1 o_csr_resp.illegal);
    sel_seen_c: cover property (i_csr_req.valid && sel_blk);
    event_seen_c: cover property (i_events != 16'h0000);

endmodule : hpc_checker

bind hpc_top hpc_checker #(.EVENT_TALLY_QUANTITY(EVENT_TALLY_QUANTITY)) chk (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_csr_req(i_csr_req),
    .i_events(i_events),
    .o_csr_resp(o_csr_resp)
);

/* verification/hpc_pipe_model.sv */
// Purpose: Pipeline side: CSR accesses and event pulses
// Assumes: Driven after falling edges, answer read one later
// Notes:   Idle address and data fields flip; valid drops, op and the other fields hold
`timescale 1ns/1ps

module hpc_pipe_model (
    input wire logic i_clk, // Core clock
    input wire hpc_pkg::hpc_csr_resp_type i_csr_resp, // CSR answer
    output hpc_pkg::hpc_csr_req_type o_csr_req, // CSR request
    output hpc_pkg::hpc_events_type o_events // Event pulses
);
    // Quiet bus at time zero
    initial begin
        o_csr_req = '0;
        o_events = '0;
    end

    // One access; reads are set with a zero source
    task automatic csr(input logic [1:0] op, input logic [11:0] addr, input logic [31:0] wdata,
        input logic imm, output logic [31:0] rdata, output logic illegal);
        @(negedge i_clk);
        o_csr_req.valid = 1'b1;
        o_csr_req.op = hpc_pkg::hpc_csr_op_type'(op);
        o_csr_req.use_imm = imm;
        o_csr_req.uimm = wdata[4:0];
        o_csr_req.src_zero = imm ? (wdata[4:0] == 5'h00) : (wdata == 32'h0);
        o_csr_req.addr = addr;
        o_csr_req.wdata = imm ? ~wdata : wdata;
        @(negedge i_clk);
        rdata = i_csr_resp.rdata;
        illegal = i_csr_resp.illegal;
        // Released address and data flip so stale data is never mistaken
        o_csr_req.valid = 1'b0;
        o_csr_req.addr = ~o_csr_req.addr;
        o_csr_req.wdata = ~o_csr_req.wdata;
    endtask : csr

    // Events held high over n rising edges
    task automatic pulse(input logic [15:0] ev, input int n);
        @(negedge i_clk);
        o_events = hpc_pkg::hpc_events_type'(ev);
        repeat (n) @(negedge i_clk);
        o_events = '0;
    endtask : pulse

endmodule : hpc_pipe_model

/* verification/hpc_performance_counters_tb.sv */
// Purpose: Self-checking bench of the counter unit
// Assumes: One event tally, inputs change on falling edges
// Notes:   Counts are frozen by inhibit, or by quiet events, before reading back
`timescale 1ns/1ps

module hpc_performance_counters_tb;
    localparam int NTALLY = 1;
    localparam logic [31:0] INH_ALL = 32'h0000_0005 | (((32'h0000_0001 << NTALLY) - 32'h0000_0001) << 3);

    logic i_clk;
    logic i_reset;
    hpc_pkg::hpc_csr_req_type req;
    hpc_pkg::hpc_events_type ev;
    hpc_pkg::hpc_csr_resp_type resp;
    int mismatches;
    int n_checks;
    logic [31:0] rd;
    logic ill;

    hpc_top #(.EVENT_TALLY_QUANTITY(NTALLY)) uut (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_csr_req(req),
        .i_events(ev),
        .o_csr_resp(resp)
    );

    hpc_pipe_model pipe (
        .i_clk(i_clk),
        .i_csr_resp(resp),
        .o_csr_req(req),
        .o_events(ev)
    );

    // 200 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // ----
    // Helpers
    // ----
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_ill);
        pipe.csr(2'h2, a, 32'h0, 1'b0, rd, ill);
        chk($sformatf("data at %h", a), exp, rd);
        chk($sformatf("trap at %h", a), {31'h0, exp_ill}, {31'h0, ill});
        // Answer still stands at the falling edge where it is taken
        chk($sformatf("answer at %h", a), 32'h1, {31'h0, resp.valid});
    endtask : rd_chk

    task automatic wr(input logic [1:0] op, input logic [11:0] a, input logic [31:0] d, input logic imm);
        pipe.csr(op, a, d, imm, rd, ill);
    endtask : wr

    // ----
    // Scenarios
    // ----
    task automatic test_reset();
        rd_chk(12'h320, INH_ALL, 1'b0);
        rd_chk(12'hB00, 32'h0, 1'b0);
        rd_chk(12'hB82, 32'h0, 1'b0);
        rd_chk(12'h323, 32'h0, 1'b0);
        rd_chk(12'hB04, 32'h0, 1'b0);
        rd_chk(12'hC84, 32'h0, 1'b0);
    endtask : test_reset

    task automatic test_traps();
        logic [11:0] bad [8] = '{12'hB01, 12'hB81, 12'hC01, 12'hC81, 12'h321, 12'h322, 12'h340, 12'hB20};
        foreach (bad[i]) rd_chk(bad[i], 32'h0, 1'b1);
        wr(2'h1, 12'hC03, 32'h0000_0055, 1'b0);
        chk("user write trap", 32'h1, {31'h0, ill});
        // Code 0 with a nonzero source is a read, so the alias allows it
        wr(2'h0, 12'hC03, 32'h0000_0055, 1'b0);
        chk("no-op alias trap", 32'h0, {31'h0, ill});
        chk("no-op alias read", 32'h0, rd);
    endtask : test_traps

    task automatic test_ops();
        logic [1:0] op [6] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h3, 2'h2};
        logic im [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        logic [31:0] d [6] = '{32'hFFFF_0020, 32'h4, 32'h20, 32'h8, 32'h8, 32'h10};
        logic [31:0] e [6] = '{32'h20, 32'h24, 32'h4, 32'h8, 32'h0, 32'h10};
        for (int i = 0; i < 6; i++) begin
            wr(op[i], 12'h323, d[i], im[i]);
            rd_chk(12'h323, e[i], 1'b0);
        end
        wr(2'h1, 12'hB03, 32'h1234_5678, 1'b0);
        wr(2'h1, 12'hB83, 32'h0000_00A5, 1'b0);
        rd_chk(12'hC03, 32'h1234_5678, 1'b0);
        rd_chk(12'hC83, 32'h0000_00A5, 1'b0);
    endtask : test_ops

    task automatic test_cycle();
        wr(2'h1, 12'hB00, 32'hFFFF_FFFE, 1'b0);
        wr(2'h1, 12'hB80, 32'h0, 1'b0);
        wr(2'h3, 12'h320, 32'h1, 1'b1);
        wr(2'h2, 12'h320, 32'h1, 1'b1);
        rd_chk(12'hB00, 32'h0, 1'b0);
        rd_chk(12'hB80, 32'h1, 1'b0);
        rd_chk(12'hB80, 32'h1, 1'b0);
        wr(2'h3, 12'h320, 32'h4, 1'b1);
        pipe.pulse(16'h0002, 3);
        wr(2'h2, 12'h320, 32'h4, 1'b1);
        rd_chk(12'hB02, 32'h3, 1'b0);
    endtask : test_cycle

    task automatic test_events();
        wr(2'h1, 12'hB83, 32'h0, 1'b0);
        wr(2'h1, 12'hB03, 32'h0, 1'b0);
        wr(2'h3, 12'h320, 32'h8, 1'b1);
        wr(2'h1, 12'h323, 32'h0, 1'b0);
        pipe.pulse(16'hFFFF, 4);
        rd_chk(12'hB03, 32'h0, 1'b0);
        for (int k = 0; k < 16; k++) begin
            wr(2'h1, 12'hB03, 32'h0, 1'b0);
            wr(2'h1, 12'h323, 32'h1 << k, 1'b0);
            pipe.pulse(~(16'h1 << k), 3);
            pipe.pulse(16'h1 << k, 2);
            rd_chk(12'hB03, 32'h2, 1'b0);
        end
        wr(2'h2, 12'h320, 32'h8, 1'b1);
        pipe.pulse(16'hFFFF, 3);
        rd_chk(12'hB03, 32'h2, 1'b0);
        rd_chk(12'hB83, 32'h0, 1'b0);
    endtask : test_events

    // ----
    // Verdict and run control
    // ----
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    // Watchdog well beyond the few hundred cycles needed
    initial begin
        #100000;
        mismatches++;
        summarize();
    end

    initial begin
        mismatches = 0;
        n_checks = 0;
        i_reset = 1'b1;
        repeat (5) @(posedge i_clk);
        @(negedge i_clk);
        i_reset = 1'b0;
        test_reset();
        test_traps();
        test_ops();
        test_cycle();
        test_events();
        summarize();
    end

endmodule : hpc_performance_counters_tb
